// file: src/csc_defines.vh
// Register map, field positions, reset values and timing counts for the conversion sequencer
`ifndef CSC_DEFINES_VH
`define CSC_DEFINES_VH

// ----------------------------------------
// Command byte addresses
// ----------------------------------------
`define CSC_ADDR_STATUS       8'h02
`define CSC_ADDR_MAIN_CFG     8'h03
`define CSC_ADDR_INTERVAL     8'h04
`define CSC_ADDR_CHAN_EN      8'h05
`define CSC_ADDR_FILTER       8'h06
`define CSC_ADDR_ONE_SHOT     8'h0f

// ----------------------------------------
// Field positions and writable masks
// ----------------------------------------
`define CSC_CFG_HOLD_BIT      6
`define CSC_CFG_Q4_BIT        1
`define CSC_CFG_Q3_BIT        0
`define CSC_CFG_MASK          8'h43
`define CSC_INTERVAL_MASK     8'h03
`define CSC_CHAN_EN_MASK      8'h1f
`define CSC_FILTER_MASK       8'h0f
`define CSC_STATUS_BUSY_BIT   7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSC_CFG_RESET         8'h03
`define CSC_INTERVAL_RESET    8'h02
`define CSC_CHAN_EN_RESET     8'h1f
`define CSC_FILTER_RESET      8'h0f

// ----------------------------------------
// Interval codes
// ----------------------------------------
`define CSC_IVL_CONT          2'b00
`define CSC_IVL_364MS         2'b01
`define CSC_IVL_1S            2'b10
`define CSC_IVL_2500MS        2'b11

// ----------------------------------------
// Timing: times in microseconds, clock period in ns
// ----------------------------------------
`define CSC_CLK_PERIOD_NS     100
`define CSC_IVL_364MS_US      364000
`define CSC_IVL_1S_US         1000000
`define CSC_IVL_2500MS_US     2500000
`define CSC_CONV_TIME_US      6000
// Divide first: microseconds times 1000 would overflow 32 bits at 2.5 s
`define CSC_US_TO_CYC(t)      ((t) * (1000 / `CSC_CLK_PERIOD_NS))

`endif

// file: src/csc_interval_timer.v
// Interval timer: counts one full pass interval and flags its end
`default_nettype none
`include "csc_defines.vh"

module csc_interval_timer #(
   parameter [31:0] IVL_364MS_CYC  = `CSC_US_TO_CYC(`CSC_IVL_364MS_US),
   parameter [31:0] IVL_1S_CYC     = `CSC_US_TO_CYC(`CSC_IVL_1S_US),
   parameter [31:0] IVL_2500MS_CYC = `CSC_US_TO_CYC(`CSC_IVL_2500MS_US)
) (
   input  wire        clock_in,
   input  wire        rst_n_in,
   input  wire        start_in,
   input  wire [1:0]  select_in,
   output wire        expired_out
);

   reg  [31:0] count_reg;
   reg  [31:0] count_next;
   reg  [31:0] limit;

   // ----------------------------------------
   // Interval length by code
   // ----------------------------------------
   always @* begin
      case (select_in)
         `CSC_IVL_364MS:  limit = IVL_364MS_CYC;
         `CSC_IVL_1S:     limit = IVL_1S_CYC;
         `CSC_IVL_2500MS: limit = IVL_2500MS_CYC;
         default:         limit = 32'h0000_0001;
      endcase
   end

   // Restart on start, saturate at the limit so the flag holds
   always @* begin
      if (start_in) begin
         count_next = 32'h0000_0001;
      end else if (count_reg < limit) begin
         count_next = count_reg + 32'h0000_0001;
      end else begin
         count_next = count_reg;
      end
   end

   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         count_reg <= 32'h0000_0000;
      end else begin
         count_reg <= count_next;
      end
   end

   // Fixed-rate codes keep interval constant for any pass shorter than it
   assign expired_out = (count_reg >= limit);

endmodule // csc_interval_timer
`default_nettype wire

// file: src/csc_channel_picker.v
// Channel picker: next enabled channel at or above a start index
`default_nettype none

module csc_channel_picker (
   input  wire [4:0]  enables_in,
   input  wire [2:0]  from_in,
   output reg         found_out,
   output reg  [2:0]  channel_out
);

   integer i;

   // ----------------------------------------
   // Lowest enabled channel not below from_in; disabled ones cost nothing
   // ----------------------------------------
   always @* begin
      found_out   = 1'b0;
      channel_out = 3'h0;
      for (i = 4; i >= 0; i = i - 1) begin
         if (enables_in[i] && (i >= from_in)) begin
            found_out   = 1'b1;
            channel_out = i[2:0];
         end
      end
   end

endmodule // csc_channel_picker
`default_nettype wire

// file: src/csc_sequencer.v
// Conversion sequencer control: registers, one-shot trigger and pass state machine
// How it works
// - Standby bit 6 set stops periodic passes; clear means continuous passes at the chosen interval.
// - In standby a write to command 0x0f starts one pass over all enabled channels.
// - The byte written to the one-shot address is discarded; only the write event counts.
// - Config bit 1 enables the remote 4 spike queue and bit 0 the remote 3 spike queue.
// - Interval code 00 is continuous, 01 is 0.364 s, 10 is 1 s, 11 is 2.5 s.
// - Each periodic pass converts enabled channels in turn, then idles out the rest of the interval.
// - Channels whose enable bit is 0 are skipped and take no time.
// - Skipping shortens continuous passes; timed codes stretch the idle so the interval holds.
// - Channel enable bits 4..0 are remote 4..1 and local, reset value 0x1f.
// - Filter bits 3-2 are remote 2 mode and 1-0 remote 1 mode: 00 off, 01 basic, 11 enhanced.
// - Reserved bits of the four registers always read zero.
// - Status bit 7 reads 1 while a conversion pass is running.
//
// ----------------------------------------
// Limits and trade-offs
// ----------------------------------------
// The interval is timed from each pass start, so a pass that outlasts the
// interval starts the next one at once rather than stretching the period.
// Setting standby mid-pass lets the running pass finish, so no channel is
// left half converted; the wait stage then sees standby and drops to idle.
// A one-shot write during a pass is dropped, not queued: the host can see
// busy in status and retry once it clears.
// Enables are sampled at every pick, so a change made during a pass takes
// effect from the next channel on.
// Filter code 10 is stored as written; keeping it out is up to the host.
// Conversion time per channel is a parameter, not a measured figure.
// Reset leaves standby clear, so passes start right after release.
`default_nettype none
`include "csc_defines.vh"

module csc_sequencer #(
   parameter [31:0] CONV_CYC       = `CSC_US_TO_CYC(`CSC_CONV_TIME_US),
   parameter [31:0] IVL_364MS_CYC  = `CSC_US_TO_CYC(`CSC_IVL_364MS_US),
   parameter [31:0] IVL_1S_CYC     = `CSC_US_TO_CYC(`CSC_IVL_1S_US),
   parameter [31:0] IVL_2500MS_CYC = `CSC_US_TO_CYC(`CSC_IVL_2500MS_US)
) (
   input  wire        clock_in,
   input  wire        rst_n_in,
   input  wire        wr_strobe_in,
   input  wire        rd_strobe_in,
   input  wire [7:0]  cmd_addr_in,
   input  wire [7:0]  wr_data_in,
   output reg  [7:0]  rd_data_out,
   output reg         rd_valid_out,
   output reg         convert_start_out,
   output reg  [2:0]  convert_channel_out,
   output reg         busy_out,
   output reg         remote4_spike_queue_en_out,
   output reg         remote3_spike_queue_en_out,
   output reg  [1:0]  remote2_filter_mode_out,
   output reg  [1:0]  remote1_filter_mode_out
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam [3:0] ST_IDLE  = 4'b0001;
   localparam [3:0] ST_PICK  = 4'b0010;
   localparam [3:0] ST_CONV  = 4'b0100;
   localparam [3:0] ST_WAIT  = 4'b1000;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   reg  [7:0]  cfg_reg;
   reg  [7:0]  interval_reg;
   reg  [7:0]  chan_en_reg;
   reg  [7:0]  filter_reg;
   reg  [3:0]  state_reg;
   reg  [3:0]  state_next;
   reg  [2:0]  next_chan_reg;
   reg  [2:0]  next_chan_next;
   reg  [31:0] conv_cnt_reg;
   reg  [31:0] conv_cnt_next;
   reg         one_shot_reg;
   reg         one_shot_next;
   reg         start_pulse;
   reg  [7:0]  rd_mux;
   wire        hold_bit;
   wire        pick_found;
   wire [2:0]  pick_chan;
   wire        ivl_expired;
   wire        trigger_write;
   wire        pass_start;

   // Masked store keeps reserved bits at zero
   function [7:0] csc_masked;
      input [7:0] value;
      input [7:0] mask;
      begin
         csc_masked = value & mask;
      end
   endfunction

   assign hold_bit      = cfg_reg[`CSC_CFG_HOLD_BIT];
   // Any write to the trigger address fires; data is never looked at
   assign trigger_write = wr_strobe_in && (cmd_addr_in == `CSC_ADDR_ONE_SHOT);

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // Reserved bits are masked on the way in, so reads need no masking
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         cfg_reg      <= `CSC_CFG_RESET;
         interval_reg <= `CSC_INTERVAL_RESET;
         chan_en_reg  <= `CSC_CHAN_EN_RESET;
         filter_reg   <= `CSC_FILTER_RESET;
      end else if (wr_strobe_in) begin
         case (cmd_addr_in)
            `CSC_ADDR_MAIN_CFG: cfg_reg      <= csc_masked(wr_data_in, `CSC_CFG_MASK);
            `CSC_ADDR_INTERVAL: interval_reg <= csc_masked(wr_data_in, `CSC_INTERVAL_MASK);
            `CSC_ADDR_CHAN_EN:  chan_en_reg  <= csc_masked(wr_data_in, `CSC_CHAN_EN_MASK);
            // Code 10 is stored as written; host must avoid it
            `CSC_ADDR_FILTER:   filter_reg   <= csc_masked(wr_data_in, `CSC_FILTER_MASK);
            default: begin
               // Status, one-shot and unmapped addresses store nothing
            end
         endcase
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   always @* begin
      case (cmd_addr_in)
         `CSC_ADDR_STATUS:   rd_mux = {busy_out, 7'h00};
         `CSC_ADDR_MAIN_CFG: rd_mux = cfg_reg;
         `CSC_ADDR_INTERVAL: rd_mux = interval_reg;
         `CSC_ADDR_CHAN_EN:  rd_mux = chan_en_reg;
         `CSC_ADDR_FILTER:   rd_mux = filter_reg;
         default:            rd_mux = 8'h00;
      endcase
   end

   // ----------------------------------------
   // Read data register
   // ----------------------------------------
   // Data is caught at the strobe edge and then held, so a slow host
   // may pick it up late without it changing under it
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         rd_data_out  <= 8'h00;
         rd_valid_out <= 1'b0;
      end else begin
         rd_valid_out <= rd_strobe_in;
         if (rd_strobe_in) begin
            rd_data_out <= rd_mux;
         end
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Pure logic: finds the next enabled channel in the same cycle
   csc_channel_picker u_picker (
      .enables_in  (chan_en_reg[4:0]),
      .from_in     (next_chan_reg),
      .found_out   (pick_found),
      .channel_out (pick_chan)
   );

   // Count runs from pass start and saturates, so expiry holds
   csc_interval_timer #(
      .IVL_364MS_CYC  (IVL_364MS_CYC),
      .IVL_1S_CYC     (IVL_1S_CYC),
      .IVL_2500MS_CYC (IVL_2500MS_CYC)
   ) u_timer (
      .clock_in    (clock_in),
      .rst_n_in    (rst_n_in),
      .start_in    (pass_start),
      .select_in   (interval_reg[1:0]),
      .expired_out (ivl_expired)
   );

   // Interval is measured from pass start, so short passes just wait longer
   assign pass_start = (state_reg == ST_IDLE) && (state_next == ST_PICK);

   // ----------------------------------------
   // Pass state machine
   // ----------------------------------------
   // IDLE decides whether a pass begins, PICK finds the next enabled
   // channel, CONV counts out one conversion and WAIT holds off until the
   // interval ends. Defaults first so every path assigns every next value.
   always @* begin
      state_next     = state_reg;
      next_chan_next = next_chan_reg;
      conv_cnt_next  = conv_cnt_reg;
      one_shot_next  = one_shot_reg;
      start_pulse    = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (!hold_bit) begin
               // Active: passes run back to back at the interval
               state_next     = ST_PICK;
               next_chan_next = 3'h0;
               one_shot_next  = 1'b0;
            end else if (trigger_write) begin
               state_next     = ST_PICK;
               next_chan_next = 3'h0;
               one_shot_next  = 1'b1;
            end
         end
         ST_PICK: begin
            if (pick_found) begin
               state_next     = ST_CONV;
               start_pulse    = 1'b1;
               conv_cnt_next  = 32'h0000_0001;
               next_chan_next = pick_chan;
            end else if (one_shot_reg) begin
               state_next = ST_IDLE;
            end else begin
               state_next = ST_WAIT;
            end
         end
         ST_CONV: begin
            if (conv_cnt_reg >= CONV_CYC) begin
               state_next = ST_PICK;
               // Past the last channel the index reaches 5 and the picker finds none
               if (next_chan_reg == 3'h4) begin
                  next_chan_next = 3'h5;
               end else begin
                  next_chan_next = next_chan_reg + 3'h1;
               end
            end else begin
               conv_cnt_next = conv_cnt_reg + 32'h0000_0001;
            end
         end
         ST_WAIT: begin
            // Continuous code expires at once; timed codes idle out the rest
            if (hold_bit && trigger_write) begin
               // Standby already in force: the trigger must not be lost here
               state_next     = ST_PICK;
               next_chan_next = 3'h0;
               one_shot_next  = 1'b1;
            end else if (hold_bit || ivl_expired) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   // Counter and index reset with the state, so a reset mid-pass is clean
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         state_reg     <= ST_IDLE;
         next_chan_reg <= 3'h0;
         conv_cnt_reg  <= 32'h0000_0000;
         one_shot_reg  <= 1'b0;
      end else begin
         state_reg     <= state_next;
         next_chan_reg <= next_chan_next;
         conv_cnt_reg  <= conv_cnt_next;
         one_shot_reg  <= one_shot_next;
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         convert_start_out          <= 1'b0;
         convert_channel_out        <= 3'h0;
         busy_out                   <= 1'b0;
         remote4_spike_queue_en_out <= 1'b1;
         remote3_spike_queue_en_out <= 1'b1;
         remote2_filter_mode_out    <= 2'b11;
         remote1_filter_mode_out    <= 2'b11;
      end else begin
         convert_start_out <= start_pulse;
         if (start_pulse) begin
            convert_channel_out <= pick_chan;
         end
         // Busy follows the next state so status and start pulse line up
         busy_out                   <= (state_next == ST_PICK) || (state_next == ST_CONV);
         // Copies trail the registers by one cycle; every output leaves a flip-flop
         remote4_spike_queue_en_out <= cfg_reg[`CSC_CFG_Q4_BIT];
         remote3_spike_queue_en_out <= cfg_reg[`CSC_CFG_Q3_BIT];
         remote2_filter_mode_out    <= filter_reg[3:2];
         remote1_filter_mode_out    <= filter_reg[1:0];
      end
   end

endmodule // csc_sequencer
`default_nettype wire

// file: test/csc_seq_checker.sv
// Port-level assertion checker for the conversion sequencer
`default_nettype none
`include "csc_defines.vh"

module csc_seq_checker (
   input wire logic       clock_in,
   input wire logic       rst_n_in,
   input wire logic       wr_strobe_in,
   input wire logic       rd_strobe_in,
   input wire logic [7:0] cmd_addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic [7:0] rd_data_out,
   input wire logic       rd_valid_out,
   input wire logic       convert_start_out,
   input wire logic [2:0] convert_channel_out,
   input wire logic       busy_out,
   input wire logic       remote4_spike_queue_en_out,
   input wire logic       remote3_spike_queue_en_out,
   input wire logic [1:0] remote2_filter_mode_out,
   input wire logic [1:0] remote1_filter_mode_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] en_reg;
   logic       hold_reg;
   logic [7:0] live_mask;
   logic       shot_wr;

   // Shadow of enables and standby bit, same edge as the design's registers
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         en_reg   <= 5'h1f;
         hold_reg <= 1'b0;
      end else if (wr_strobe_in && cmd_addr_in == `CSC_ADDR_CHAN_EN) begin
         en_reg <= wr_data_in[4:0];
      end else if (wr_strobe_in && cmd_addr_in == `CSC_ADDR_MAIN_CFG) begin
         hold_reg <= wr_data_in[6];
      end
   end

   // Bits that may read non-zero at the addressed place; unmapped reads all zero
   always_comb begin
      case (cmd_addr_in)
         `CSC_ADDR_STATUS:   live_mask = 8'h80;
         `CSC_ADDR_MAIN_CFG: live_mask = `CSC_CFG_MASK;
         `CSC_ADDR_INTERVAL: live_mask = `CSC_INTERVAL_MASK;
         `CSC_ADDR_CHAN_EN:  live_mask = `CSC_CHAN_EN_MASK;
         `CSC_ADDR_FILTER:   live_mask = `CSC_FILTER_MASK;
         default:            live_mask = 8'h00;
      endcase
   end
   assign shot_wr = wr_strobe_in && cmd_addr_in == `CSC_ADDR_ONE_SHOT;

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);

   read_answer_a: assert property (rd_strobe_in |=> rd_valid_out) else $error("read not answered");
   read_quiet_a: assert property (!rd_strobe_in |=> !rd_valid_out) else $error("stray read valid");
   reserved_zero_a: assert property (rd_strobe_in |=> (rd_data_out & ~$past(live_mask)) == 8'h00)
      else $error("reserved bit read non-zero");
   status_busy_a: assert property (rd_strobe_in && cmd_addr_in == `CSC_ADDR_STATUS
      |=> rd_data_out[7] == $past(busy_out)) else $error("status busy bit wrong");
   start_busy_a: assert property (convert_start_out |-> busy_out) else $error("start outside pass");
   start_gap_a: assert property (convert_start_out |=> !convert_start_out [*8]) else $error("starts too close");
   skip_off_a: assert property (convert_start_out |-> ($past(en_reg) & (5'h01 << convert_channel_out)) != 5'h00)
      else $error("disabled channel converted");
   queue_follow_a: assert property (wr_strobe_in && cmd_addr_in == `CSC_ADDR_MAIN_CFG
      |-> ##2 {6'h00, remote4_spike_queue_en_out, remote3_spike_queue_en_out} == ($past(wr_data_in, 2) & 8'h03))
      else $error("queue enables wrong");
   filter_follow_a: assert property (wr_strobe_in && cmd_addr_in == `CSC_ADDR_FILTER
      |-> ##2 {4'h0, remote2_filter_mode_out, remote1_filter_mode_out} == ($past(wr_data_in, 2) & 8'h0f))
      else $error("filter modes wrong");
   standby_quiet_a: assert property (hold_reg && !busy_out && !shot_wr |=> !busy_out)
      else $error("pass started in standby");
   one_shot_go_a: assert property (hold_reg && !busy_out && shot_wr && en_reg != 5'h00
      |=> busy_out ##1 convert_start_out) else $error("one-shot did not start");

   // Main scenarios reached
   cover property (hold_reg && !busy_out && shot_wr);
   cover property (convert_start_out && convert_channel_out == 3'd4);
   cover property (rd_valid_out && rd_data_out[7]);
endmodule // csc_seq_checker
`default_nettype wire

// file: test/csc_host_model.sv
// Register host model issuing command-byte reads and writes
`default_nettype none

module csc_host_model (
   input  wire logic       clock_in,
   input  wire logic [7:0] rd_data_in,
   input  wire logic       rd_valid_in,
   output var  logic       wr_strobe_out,
   output var  logic       rd_strobe_out,
   output var  logic [7:0] cmd_addr_out,
   output var  logic [7:0] wr_data_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle lines carry junk, never a stale address
   initial begin
      wr_strobe_out = 1'b0;
      rd_strobe_out = 1'b0;
      cmd_addr_out  = 8'h5a;
      wr_data_out   = 8'ha5;
   end

   // One write across one rising edge; reserved filter code is never sent
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      if (addr == 8'h06 && (data[3:2] == 2'b10 || data[1:0] == 2'b10)) return;
      @(negedge clock_in);
      cmd_addr_out  = addr;
      wr_data_out   = data;
      wr_strobe_out = 1'b1;
      @(negedge clock_in);
      wr_strobe_out = 1'b0;
      cmd_addr_out  = ~addr;
      wr_data_out   = ~data;
   endtask

   // One read; the answer stands in the cycle after the strobe
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      @(negedge clock_in);
      cmd_addr_out  = addr;
      rd_strobe_out = 1'b1;
      @(negedge clock_in);
      rd_strobe_out = 1'b0;
      cmd_addr_out  = ~addr;
      ok            = rd_valid_in;
      data          = rd_data_in;
   endtask
endmodule // csc_host_model
`default_nettype wire

// file: test/tb.sv
// Testbench: register map, one-shot passes and interval timing of the sequencer
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int         IVL[4] = '{0, 200, 300, 400};
   localparam logic [7:0] RES[4] = '{8'h43, 8'h03, 8'h1f, 8'h0f};
   localparam logic [1:0] FC[3]  = '{2'b00, 2'b01, 2'b11};
   logic            clock_in = 1'b0;
   logic            rst_n_in = 1'b0;
   wire logic       wr_s, rd_s, rd_v, c_st, busy, q4, q3;
   wire logic [7:0] addr, wdat, rdat;
   wire logic [2:0] c_ch;
   wire logic [1:0] f2, f1;
   int              error_cnt = 0;
   int              checks = 0;
   int              pone[4], pall[4];
   logic [2:0]      q[$];

   always #50 clock_in = ~clock_in;

   csc_sequencer #(.CONV_CYC(32'd20), .IVL_364MS_CYC(32'd200), .IVL_1S_CYC(32'd300), .IVL_2500MS_CYC(32'd400)) uut (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .wr_strobe_in(wr_s), .rd_strobe_in(rd_s), .cmd_addr_in(addr),
      .wr_data_in(wdat), .rd_data_out(rdat), .rd_valid_out(rd_v), .convert_start_out(c_st),
      .convert_channel_out(c_ch), .busy_out(busy), .remote4_spike_queue_en_out(q4),
      .remote3_spike_queue_en_out(q3), .remote2_filter_mode_out(f2), .remote1_filter_mode_out(f1));

   csc_host_model host (.clock_in(clock_in), .rd_data_in(rdat), .rd_valid_in(rd_v), .wr_strobe_out(wr_s),
      .rd_strobe_out(rd_s), .cmd_addr_out(addr), .wr_data_out(wdat));

   // Log every channel start, seen where the one-cycle pulse is settled
   always @(negedge clock_in) begin
      if (c_st === 1'b1) q.push_back(c_ch);
   end

   task automatic complete_run();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_int(input int got, input int exp);
      checks++;
      if (got != exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      host.read_reg(a, d, ok);
      cmp8(ok === 1'b1 ? d : ~exp, exp);
   endtask

   // Bounded waits: a hang counts as a mismatch and ends the run
   task automatic wait_idle();
      int n = 0;
      repeat (3) @(negedge clock_in);
      while (busy !== 1'b0) begin
         @(negedge clock_in);
         n++;
         if (n > 2000) begin error_cnt++; complete_run(); end
      end
   endtask

   task automatic next_start(output int n);
      n = 0;
      do begin
         @(negedge clock_in);
         n++;
         if (n > 2000) begin error_cnt++; complete_run(); end
      end while (!(c_st === 1'b1 && c_ch === 3'd0));
   endtask

   // Second start-to-start gap after a code change, clear of the switch-over
   task automatic measure(input int c, output int p);
      host.write_reg(8'h04, c[7:0]);
      next_start(p);
      next_start(p);
      next_start(p);
   endtask

   initial begin
      repeat (8) @(negedge clock_in);
      rst_n_in = 1'b1;
      for (int i = 0; i < 4; i++) chk_reg(8'h03 + i[7:0], RES[i] & {6'h3f, 2'b11} & (i == 0 ? 8'h03 : RES[i] == 8'h03 ? 8'h02 : 8'hff));
      cmp8({2'b00, q4, q3, f2, f1}, 8'h3f);
      chk_reg(8'h10, 8'h00);
      chk_reg(8'h0f, 8'h00);
      for (int a = 3; a < 7; a++) host.write_reg(a[7:0], 8'hff);
      for (int i = 0; i < 4; i++) chk_reg(8'h03 + i[7:0], RES[i]);
      wait_idle();
      for (int i = 0; i < 3; i++) begin
         host.write_reg(8'h06, {4'h0, FC[i], FC[2 - i]});
         @(negedge clock_in); // Output copies trail the register by one cycle
         cmp8({4'h0, f2, f1}, {4'h0, FC[i], FC[2 - i]});
      end
      for (int i = 0; i < 4; i++) begin
         host.write_reg(8'h03, {6'h10, i[1:0]});
         @(negedge clock_in); // Output copies trail the register by one cycle
         cmp8({6'h00, q4, q3}, {6'h00, i[1:0]});
      end
      host.write_reg(8'h05, 8'h15);
      q.delete();
      host.write_reg(8'h0f, 8'ha5);
      host.write_reg(8'h0f, 8'h5a);
      chk_reg(8'h02, 8'h80);
      wait_idle();
      repeat (500) @(negedge clock_in);
      cmp_int(q.size(), 3);
      for (int i = 0; i < 3; i++) cmp8({5'h00, q[i]}, {4'h0, i[2:0], 1'b0});
      chk_reg(8'h03, 8'h43);
      chk_reg(8'h02, 8'h00);
      host.write_reg(8'h05, 8'h01);
      host.write_reg(8'h03, 8'h00);
      for (int c = 0; c < 4; c++) measure(c, pone[c]);
      host.write_reg(8'h03, 8'h40);
      wait_idle();
      host.write_reg(8'h05, 8'h1f);
      host.write_reg(8'h03, 8'h00);
      for (int c = 0; c < 4; c++) measure(c, pall[c]);
      cmp_int(pone[0] < pall[0], 1);
      for (int c = 1; c < 4; c++) begin
         cmp_int(pone[c] >= IVL[c] - 1 && pone[c] <= IVL[c] + 1, 1);
         cmp_int(pall[c], pone[c]);
      end
      complete_run();
   end
endmodule // tb

bind csc_sequencer csc_seq_checker chk (.clock_in(clock_in), .rst_n_in(rst_n_in), .wr_strobe_in(wr_strobe_in),
   .rd_strobe_in(rd_strobe_in), .cmd_addr_in(cmd_addr_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
   .rd_valid_out(rd_valid_out), .convert_start_out(convert_start_out), .convert_channel_out(convert_channel_out),
   .busy_out(busy_out), .remote4_spike_queue_en_out(remote4_spike_queue_en_out),
   .remote3_spike_queue_en_out(remote3_spike_queue_en_out), .remote2_filter_mode_out(remote2_filter_mode_out),
   .remote1_filter_mode_out(remote1_filter_mode_out));
`default_nettype wire
